// ==== rtl/dcrr_defines.svh ====
`ifndef DCRR_DEFINES_SVH
`define DCRR_DEFINES_SVH
`define DCRR_OFS_CAL_CTRL     5'h0E
`define DCRR_OFS_CAL_STAT     5'h0F
`define DCRR_OFS_MEM_ADDR     5'h10
`define DCRR_OFS_MEM_DATA     5'h11
`define DCRR_OFS_MEM_CMD      5'h12
`define DCRR_OFS_PHASE        5'h14
`define DCRR_OFS_VERSION      5'h1F
`define DCRR_BIT_PRELD_Q      7
`define DCRR_BIT_PRELD_I      6
`define DCRR_BIT_CALSEL_Q     5
`define DCRR_BIT_CALSEL_I     4
`define DCRR_BIT_CAL_CLOCK_ENABLE_EN    3
`define DCRR_BIT_CLR_Q        7
`define DCRR_BIT_CLR_I        6
`define DCRR_BIT_START        4
`define DCRR_BIT_MEM_WR       3
`define DCRR_BIT_MEM_RD       2
`define DCRR_BIT_UNCAL_Q      1
`define DCRR_BIT_UNCAL_I      0
`define DCRR_BIT_SEARCH       4
`define DCRR_BIT_REACQ        3
`define DCRR_BIT_OVERRIDE     2
`define DCRR_PRELOAD_DEFAULT  6'h20
`define DCRR_PRELOAD_ADDR     6'h01
`define DCRR_COEFF_DEFAULT    6'h00
`define DCRR_MEM_UNCAL        2'h0
`define DCRR_MEM_SELF         2'h1
`define DCRR_MEM_USER         2'h2
`define DCRR_CAL_STEPS        8'h40
`define DCRR_SEARCH_CYCLES    8'h10
// arbitrary value, chosen only to be recognisable
`define DCRR_VERSION_CODE     8'h5A
`endif

// ==== rtl/dcrr_pkg.sv ====
package dcrr_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_PRELOAD, CAL_RUN} dcrr_cal_state_t;
  typedef struct packed {
    logic       write_en;
    logic [4:0] addr;
    logic [7:0] wdata;
  } dcrr_bus_req_t;
  typedef struct packed {
    logic [1:0] i_phase;
    logic [1:0] q_phase;
  } dcrr_phase_t;
  typedef struct packed {
    logic [1:0]      rst_sync;
    logic [7:0]      cal_ctrl;
    logic [5:0]      mem_addr;
    logic [5:0]      mem_data;
    logic [1:0]      complete;
    logic [1:0]      mem_state_i;
    logic [1:0]      mem_state_q;
    logic            override;
    logic            reacq;
    logic            searching;
    logic [7:0]      search_cnt;
    dcrr_phase_t     forced;
    dcrr_phase_t     to_retimer;
    logic [7:0]      div_cnt;
    logic            cal_tick;
    dcrr_cal_state_t cal_state;
    logic [1:0]      cal_chan;
    logic [7:0]      cal_cnt;
    logic [5:0]      ref_val;
    logic            user_set;
  } dcrr_state_t;
endpackage

// ==== rtl/dcrr_regs.sv ====
// Summary of operation
// - preload bit 0 uses reference 32; bit 1 uses user value at location 1.
// - per-channel select bit includes that channel in self-calibration; default unselected.
// - calibration clock runs only while its enable bit is 1; reset stops it.
// - divider code 000 divides by 256, 001 by 128, 110 by 4, 111 by 2.
// - read-only completion flag per channel, 1 once its calibration completes.
// - 2-bit memory state per channel: 00 uncalibrated, 01 self, 10 user.
// - 6-bit address register selects coefficient location for read or write commands.
// - 6-bit data register holds write value and receives read result.
// - writing 1 to start bit begins self-calibration of selected channels.
// - write command stores data register at addressed coefficient location.
// - read command fetches addressed coefficient into data register.
// - uncalibrate bit restores that channel's coefficients to default values.
// - with override 0, phase fields are read-only and show retimer's chosen phase.
// - with override 1, phase fields become writable to force retimer phase.
// - override 1 drives both retimers from I field; 0 uses each own phase.
// - search status reads 1 while retimer searches, 0 once relationship is found.
// - a 0-to-1 write of reacquire bit restarts the retimer search.
// - 8-bit read-only register returns a fixed hardware revision code.
`timescale 1ns/10ps
`include "dcrr_defines.svh"
module dcrr_regs (
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire dcrr_pkg::dcrr_bus_req_t bus_req,
  output logic [7:0]                  rdata,
  input  wire dcrr_pkg::dcrr_phase_t  auto_phase,
  output dcrr_pkg::dcrr_phase_t       retimer_phase,
  output logic                        retimer_search,
  output logic                        cal_clock_tick,
  output logic [5:0]                  cal_reference
);
  // coefficient memory: 64 entries per channel, entry index = address
  logic [5:0]            coeff_i [0:63];
  logic [5:0]            coeff_q [0:63];
  dcrr_pkg::dcrr_state_t st_r;
  dcrr_pkg::dcrr_state_t st_nxt;
  logic                  rst_n_int;
  logic                  wr_cal_ctrl;
  logic                  wr_mem_cmd;
  logic                  wr_phase;
  logic [7:0]            div_len;
  logic                  restore_i;
  logic                  restore_q;
  logic                  store_cmd;
  logic [5:0]            preload_i;
  logic [5:0]            preload_q;
  logic                  wr_mem_addr;
  logic                  wr_mem_data;
  logic                  fetch_cmd;
  logic                  start_cmd;
  logic                  clear_i;
  logic                  clear_q;
  logic                  reacq_rise;
  logic [1:0]            start_chan;
  logic [7:0]            status_rd;
  logic [1:0]            rd_phase_i;
  logic [1:0]            rd_phase_q;

  assign rst_n_int = st_r.rst_sync[1];
  assign wr_cal_ctrl = bus_req.write_en && bus_req.addr == `DCRR_OFS_CAL_CTRL;
  assign wr_mem_cmd = bus_req.write_en && bus_req.addr == `DCRR_OFS_MEM_CMD;
  assign wr_phase = bus_req.write_en && bus_req.addr == `DCRR_OFS_PHASE;
  assign restore_i = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_UNCAL_I];
  assign restore_q = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_UNCAL_Q];
  assign store_cmd = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_MEM_WR];
  assign wr_mem_addr = bus_req.write_en && bus_req.addr == `DCRR_OFS_MEM_ADDR;
  assign wr_mem_data = bus_req.write_en && bus_req.addr == `DCRR_OFS_MEM_DATA;
  assign fetch_cmd = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_MEM_RD];
  assign start_cmd = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_START];
  assign clear_i = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_CLR_I];
  assign clear_q = wr_mem_cmd && bus_req.wdata[`DCRR_BIT_CLR_Q];
  // only a rising edge of the stored bit restarts; rewriting 1 does nothing
  assign reacq_rise = wr_phase && bus_req.wdata[`DCRR_BIT_REACQ] && !st_r.reacq;
  assign start_chan = {st_r.cal_ctrl[`DCRR_BIT_CALSEL_Q], st_r.cal_ctrl[`DCRR_BIT_CALSEL_I]};
  assign status_rd = {st_r.complete[1], st_r.complete[0], 2'h0, st_r.mem_state_q, st_r.mem_state_i};
  // override shows the forced fields; otherwise the live computed phase
  assign rd_phase_i = st_r.override ? st_r.forced.i_phase : auto_phase.i_phase;
  assign rd_phase_q = st_r.override ? st_r.forced.q_phase : auto_phase.q_phase;
  assign preload_i = st_r.cal_ctrl[`DCRR_BIT_PRELD_I] ? coeff_i[`DCRR_PRELOAD_ADDR] : `DCRR_PRELOAD_DEFAULT;
  assign preload_q = st_r.cal_ctrl[`DCRR_BIT_PRELD_Q] ? coeff_q[`DCRR_PRELOAD_ADDR] : `DCRR_PRELOAD_DEFAULT;

  // divide ratio minus one: 256 >> code
  always_comb
  begin
    unique case (st_r.cal_ctrl[2:0])
      3'h0: div_len = 8'hFF;
      3'h1: div_len = 8'h7F;
      3'h2: div_len = 8'h3F;
      3'h3: div_len = 8'h1F;
      3'h4: div_len = 8'h0F;
      3'h5: div_len = 8'h07;
      3'h6: div_len = 8'h03;
      3'h7: div_len = 8'h01;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rst_sync = {st_r.rst_sync[0], 1'b1};
    st_nxt.cal_tick = 1'b0;
    if (wr_cal_ctrl)
    begin
      st_nxt.cal_ctrl = bus_req.wdata;
    end
    if (wr_mem_addr)
    begin
      st_nxt.mem_addr = bus_req.wdata[5:0];
    end
    if (wr_mem_data)
    begin
      st_nxt.mem_data = bus_req.wdata[5:0];
    end
    // read port returns the I bank; I and Q share one address space view
    if (fetch_cmd)
    begin
      st_nxt.mem_data = coeff_i[st_r.mem_addr];
    end
    if (store_cmd)
    begin
      st_nxt.mem_state_i = `DCRR_MEM_USER;
      st_nxt.mem_state_q = `DCRR_MEM_USER;
      st_nxt.user_set = 1'b1;
    end
    if (restore_i)
    begin
      st_nxt.mem_state_i = `DCRR_MEM_UNCAL;
    end
    if (restore_q)
    begin
      st_nxt.mem_state_q = `DCRR_MEM_UNCAL;
    end
    // divider freewheels only while enabled, so a stopped clock restarts in phase
    if (st_r.cal_ctrl[`DCRR_BIT_CAL_CLOCK_ENABLE_EN])
    begin
      if (st_r.div_cnt >= div_len)
      begin
        st_nxt.div_cnt = 8'h00;
        st_nxt.cal_tick = 1'b1;
      end
      else
      begin
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      end
    end
    else
    begin
      st_nxt.div_cnt = 8'h00;
    end
    // clear first, so a completion in the same cycle wins below
    if (clear_i)
    begin
      st_nxt.complete[0] = 1'b0;
    end
    if (clear_q)
    begin
      st_nxt.complete[1] = 1'b0;
    end
    unique case (st_r.cal_state)
      dcrr_pkg::CAL_IDLE:
      begin
        if (start_cmd)
        begin
          st_nxt.cal_chan = start_chan;
          st_nxt.cal_state = dcrr_pkg::CAL_PRELOAD;
          st_nxt.complete = st_nxt.complete & ~start_chan;
        end
      end
      dcrr_pkg::CAL_PRELOAD:
      begin
        st_nxt.ref_val = st_r.cal_chan[0] ? preload_i : preload_q;
        st_nxt.cal_cnt = `DCRR_CAL_STEPS;
        st_nxt.cal_state = st_r.cal_chan == 2'h0 ? dcrr_pkg::CAL_IDLE : dcrr_pkg::CAL_RUN;
      end
      dcrr_pkg::CAL_RUN:
      begin
        // steps advance on the calibration clock only; no enable means it waits
        if (st_r.cal_tick)
        begin
          st_nxt.cal_cnt = st_r.cal_cnt - 8'h01;
          if (st_r.cal_cnt == 8'h01)
          begin
            st_nxt.complete = st_nxt.complete | st_r.cal_chan;
            if (st_r.cal_chan[0])
            begin
              st_nxt.mem_state_i = `DCRR_MEM_SELF;
            end
            if (st_r.cal_chan[1])
            begin
              st_nxt.mem_state_q = `DCRR_MEM_SELF;
            end
            st_nxt.cal_state = dcrr_pkg::CAL_IDLE;
          end
        end
      end
      // the unused fourth state code falls back to idle
      default:
      begin
        st_nxt.cal_state = dcrr_pkg::CAL_IDLE;
      end
    endcase
    if (wr_phase)
    begin
      st_nxt.override = bus_req.wdata[`DCRR_BIT_OVERRIDE];
      st_nxt.reacq = bus_req.wdata[`DCRR_BIT_REACQ];
      if (st_r.override)
      begin
        st_nxt.forced.i_phase = bus_req.wdata[1:0];
        st_nxt.forced.q_phase = bus_req.wdata[7:6];
      end
    end
    if (st_r.searching)
    begin
      st_nxt.search_cnt = st_r.search_cnt - 8'h01;
      if (st_r.search_cnt == 8'h01)
      begin
        st_nxt.searching = 1'b0;
      end
    end
    // after the countdown, so a restart in mid-search reloads the full count
    if (reacq_rise)
    begin
      st_nxt.searching = 1'b1;
      st_nxt.search_cnt = `DCRR_SEARCH_CYCLES;
    end
    if (st_r.override)
    begin
      st_nxt.to_retimer.i_phase = st_r.forced.i_phase;
      st_nxt.to_retimer.q_phase = st_r.forced.i_phase;
    end
    else
    begin
      st_nxt.to_retimer = auto_phase;
    end
  end

  // state stays cleared for two edges after rst_b rises, until the synchronised copy lets go
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else if (!rst_n_int)
    begin
      st_r <= '0;
      st_r.rst_sync <= {st_r.rst_sync[0], 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // memory is cleared while the synchronised reset is held; restore-default writes the whole bank in one cycle
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1)
    begin : g_coeff
      always_ff @(posedge clock)
      begin
        if (restore_i || !rst_n_int)
        begin
          coeff_i[gi] <= `DCRR_COEFF_DEFAULT;
        end
        else if (store_cmd && st_r.mem_addr == 6'(gi))
        begin
          coeff_i[gi] <= st_r.mem_data;
        end
        if (restore_q || !rst_n_int)
        begin
          coeff_q[gi] <= `DCRR_COEFF_DEFAULT;
        end
        else if (store_cmd && st_r.mem_addr == 6'(gi))
        begin
          coeff_q[gi] <= st_r.mem_data;
        end
      end
    end
  endgenerate

  always_comb
  begin
    unique case (bus_req.addr)
      `DCRR_OFS_CAL_CTRL: rdata = st_r.cal_ctrl;
      `DCRR_OFS_CAL_STAT: rdata = status_rd;
      `DCRR_OFS_MEM_ADDR: rdata = {2'h0, st_r.mem_addr};
      `DCRR_OFS_MEM_DATA: rdata = {2'h0, st_r.mem_data};
      `DCRR_OFS_PHASE: rdata = {rd_phase_q, 1'b0, st_r.searching, st_r.reacq, st_r.override, rd_phase_i};
      `DCRR_OFS_VERSION: rdata = `DCRR_VERSION_CODE;
      default: rdata = 8'h00;
    endcase
  end

  assign retimer_phase = st_r.to_retimer;
  assign retimer_search = st_r.searching;
  assign cal_clock_tick = st_r.cal_tick;
  assign cal_reference = st_r.ref_val;
endmodule // dcrr_regs

// ==== verification/dcrr_regs_sva.sv ====
`timescale 1ns/10ps
module dcrr_regs_sva (
  input wire logic                    clock,
  input wire logic                    rst_b,
  input wire dcrr_pkg::dcrr_bus_req_t bus_req,
  input wire logic [7:0]              rdata,
  input wire dcrr_pkg::dcrr_phase_t   auto_phase,
  input wire dcrr_pkg::dcrr_phase_t   retimer_phase,
  input wire logic                    retimer_search,
  input wire logic                    cal_clock_tick,
  input wire logic [5:0]              cal_reference
);
  logic [7:0] ctrl_r;
  logic [2:0] sync_r;
  logic       reacq_r;
  logic       ovr_r;
  logic [8:0] gap_r;
  logic [9:0] stab_r;
  logic       wr_ctl;
  logic       wr_ph;
  assign wr_ctl = bus_req.write_en && bus_req.addr == 5'h0E;
  assign wr_ph  = bus_req.write_en && bus_req.addr == 5'h14;
  // one stage beyond the design's reset sync, so its reset edges are never judged
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      {sync_r, ctrl_r, reacq_r, ovr_r, gap_r, stab_r} <= '0;
    end
    else
    begin
      sync_r  <= {sync_r[1:0], 1'b1};
      ctrl_r  <= wr_ctl ? bus_req.wdata : ctrl_r;
      reacq_r <= wr_ph ? bus_req.wdata[3] : reacq_r;
      ovr_r   <= wr_ph ? bus_req.wdata[2] : ovr_r;
      gap_r   <= cal_clock_tick ? 9'h000 : (gap_r == 9'h1FF ? gap_r : gap_r + 9'h001);
      stab_r  <= wr_ctl ? 10'h000 : (stab_r == 10'h258 ? stab_r : stab_r + 10'h001);
    end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!sync_r[2]);
  version_read_a: assert property (bus_req.addr == 5'h1F |-> rdata == 8'h5A)
    else $error("version register read wrong");
  tick_stopped_a: assert property (!ctrl_r[3] [*2] |-> !cal_clock_tick)
    else $error("calibration tick while disabled");
  tick_period_a: assert property (cal_clock_tick && stab_r == 10'h258 |-> gap_r == (9'h100 >> ctrl_r[2:0]) - 9'h001)
    else $error("calibration tick period wrong");
  search_start_a: assert property (wr_ph && bus_req.wdata[3] && !reacq_r |=> retimer_search [*8])
    else $error("reacquire did not start search");
  search_edge_a: assert property (wr_ph && bus_req.wdata[3] && reacq_r && !retimer_search |=> !retimer_search)
    else $error("search restarted on level");
  auto_phase_a: assert property (!ovr_r [*3] |-> retimer_phase == $past(auto_phase))
    else $error("retimer phase not following computed phase");
  forced_phase_a: assert property (ovr_r [*3] |-> retimer_phase.q_phase == retimer_phase.i_phase)
    else $error("forced phase not shared by both retimers");
  ro_phase_a: assert property ((!ovr_r && $stable(auto_phase)) [*2] ##0 bus_req.addr == 5'h14
    |-> rdata[7:6] == auto_phase.q_phase && rdata[1:0] == auto_phase.i_phase)
    else $error("phase readback differs from computed phase");
  preload_ref_a: assert property (bus_req.write_en && bus_req.addr == 5'h12 && bus_req.wdata[4]
    && ctrl_r[5:4] != 2'h0 && ctrl_r[7:6] == 2'h0 |-> ##[1:3] cal_reference == 6'h20)
    else $error("default preload reference wrong");
  tick_c: cover property (cal_clock_tick && stab_r == 10'h258);
  search_c: cover property ($rose(retimer_search));
  forced_c: cover property (ovr_r && wr_ph);
endmodule // dcrr_regs_sva

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic                    clock;
  logic                    rst_b;
  logic                    hold;
  dcrr_pkg::dcrr_bus_req_t bus_req;
  logic [7:0]              rdata;
  dcrr_pkg::dcrr_phase_t   auto_phase;
  dcrr_pkg::dcrr_phase_t   retimer_phase;
  logic                    retimer_search;
  logic                    cal_clock_tick;
  logic [5:0]              cal_reference;
  integer                  seed = 72;
  integer                  err_count = 0;
  integer                  comparisons = 0;
  integer                  n;
  logic [7:0]              v;
  logic [7:0]              a;
  logic [5:0]              d;
  logic [1:0]              ph;
  dcrr_regs i_dcrr_regs (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata), .auto_phase(auto_phase),
    .retimer_phase(retimer_phase), .retimer_search(retimer_search), .cal_clock_tick(cal_clock_tick),
    .cal_reference(cal_reference));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // computed phase wanders slowly; held still while readback is compared
  always @(posedge clock)
    if (rst_b && !hold && ($random(seed) & 7) == 0)
      auto_phase <= 4'($random(seed));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] w);
    @(posedge clock);
    bus_req <= '{1'b1, ad, w};
    @(posedge clock);
    bus_req.write_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] ad, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock);
    bus_req.addr <= ad;
    @(negedge clock);
    v = rdata;
    check(v & m, e);
  endtask
  task automatic wait_bit(input logic [4:0] ad, input int b, input logic val);
    @(posedge clock);
    bus_req.addr <= ad;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (rdata[b] !== val && n < 600);
    check({7'h0, rdata[b]}, {7'h0, val});
    if (rdata[b] !== val)
      conclude;
  endtask
  task automatic count_ticks(input logic [7:0] e);
    n = 0;
    repeat (256) @(negedge clock) n += (cal_clock_tick === 1'b1);
    check(n[7:0], e);
  endtask
  // a steady tick train of period 256 >> code gives 1 << code ticks per 256 cycles
  function automatic logic [7:0] ticks_per_256(input logic [2:0] code);
    return 8'h01 << code;
  endfunction
  task automatic conclude;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clock);
    err_count++;
    conclude;
  end
  initial
  begin
    rst_b = 1'b0;
    hold = 1'b0;
    bus_req = '0;
    auto_phase = '0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rdchk(5'h0E, 8'h00, 8'hFF);
    rdchk(5'h0F, 8'h00, 8'hFF);
    wr(5'h1F, 8'h00);
    wr(5'h0F, 8'hFF);
    rdchk(5'h1F, 8'h5A, 8'hFF);
    rdchk(5'h0F, 8'h00, 8'hFF);
    rdchk(5'h00, 8'h00, 8'hFF);
    repeat (4)
    begin
      a = 8'($random(seed));
      d = 6'($random(seed));
      wr(5'h10, a);
      rdchk(5'h10, a & 8'h3F, 8'h3F);
      wr(5'h11, {2'h0, d});
      wr(5'h12, 8'h08);
      wr(5'h11, {2'h0, ~d});
      rdchk(5'h11, {2'h0, ~d}, 8'h3F);
      wr(5'h12, 8'h04);
      rdchk(5'h11, {2'h0, d}, 8'h3F);
      rdchk(5'h0F, 8'h0A, 8'h0F);
      rdchk(5'h12, 8'h00, 8'hFF);
    end
    wr(5'h12, 8'h01);
    wr(5'h12, 8'h04);
    rdchk(5'h11, 8'h00, 8'h3F);
    rdchk(5'h0F, 8'h08, 8'h0F);
    d = 6'($random(seed));
    wr(5'h10, 8'h01);
    wr(5'h11, {2'h0, d});
    wr(5'h12, 8'h08);
    wr(5'h0E, 8'h5F);
    wr(5'h12, 8'h10);
    repeat (3) @(posedge clock);
    check({2'h0, cal_reference}, {2'h0, d});
    wait_bit(5'h0F, 6, 1'b1);
    rdchk(5'h0F, 8'h41, 8'hC3);
    wr(5'h12, 8'h40);
    rdchk(5'h0F, 8'h00, 8'h40);
    wr(5'h0E, 8'h2F);
    wr(5'h12, 8'h10);
    repeat (3) @(posedge clock);
    check({2'h0, cal_reference}, 8'h20);
    wait_bit(5'h0F, 7, 1'b1);
    wr(5'h12, 8'h00);
    rdchk(5'h0F, 8'h84, 8'hCC);
    for (int c = 0; c < 8; c++)
    begin
      wr(5'h0E, 8'h08 | c[7:0]);
      repeat (600) @(posedge clock);
      count_ticks(ticks_per_256(c[2:0]));
    end
    wr(5'h0E, 8'h07);
    // a tick launched under the old enable may still be showing for one cycle
    @(posedge clock);
    count_ticks(8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(5'h14, 8'h08);
      @(negedge clock) check({7'h0, retimer_search}, 8'h01);
      wait_bit(5'h14, 4, 1'b0);
      wr(5'h14, 8'h08);
      @(negedge clock) check({7'h0, retimer_search}, 8'h00);
      wr(5'h14, 8'h00);
    end
    hold = 1'b1;
    wr(5'h14, 8'hC3);
    repeat (3) @(posedge clock);
    rdchk(5'h14, {auto_phase.q_phase, 4'h0, auto_phase.i_phase}, 8'hC3);
    check({4'h0, retimer_phase}, {4'h0, auto_phase});
    hold = 1'b0;
    ph = 2'($random(seed));
    wr(5'h14, 8'h04);
    wr(5'h14, {~ph, 4'h1, ph});
    repeat (2) @(posedge clock);
    check({4'h0, retimer_phase}, {4'h0, ph, ph});
    rdchk(5'h14, {~ph, 4'h1, ph}, 8'hFF);
    wr(5'h14, 8'h00);
    repeat (8) @(posedge clock);
    conclude;
  end
endmodule // tb
bind dcrr_regs dcrr_regs_sva i_dcrr_regs_sva (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
  .auto_phase(auto_phase), .retimer_phase(retimer_phase), .retimer_search(retimer_search),
  .cal_clock_tick(cal_clock_tick), .cal_reference(cal_reference));
